// ### mci_cpu_model.sv
// Processor core stand-in: strobes acknowledge reads and end-of-service writes.
// Assumes strobes are taken at the rising edge and the answer stands one edge later.
`timescale 1ns/10ps
`default_nettype none
module mci_cpu_model
	import mci_pkg::*;
(
	// Clock
	input wire logic i_clk_sys,
	// Answer from the delivery block
	input wire logic [VEC_W-1:0] i_vec,
	input wire logic i_spur,
	// Strobes toward the delivery block
	output logic o_ack,
	output logic o_eos
);
	// Idle strobes from time zero
	initial begin
		o_ack = 1'b0;
		o_eos = 1'b0;
	end

	// Sample at the second falling edge after the taking edge, so a registered answer has landed
	task automatic ack_read(output logic [VEC_W-1:0] v, output logic s);
		@(negedge i_clk_sys) o_ack = 1'b1;
		@(negedge i_clk_sys) o_ack = 1'b0;
		@(negedge i_clk_sys);
		v = i_vec;
		s = i_spur;
	endtask

	// One-cycle end-of-service strobe
	task automatic end_service();
		@(negedge i_clk_sys) o_eos = 1'b1;
		@(negedge i_clk_sys) o_eos = 1'b0;
	endtask
endmodule // mci_cpu_model
`default_nettype wire

// ### mci_delivery.sv
// Priority, nesting and delivery logic of a two-processor interrupt unit.
// Assumes all inputs synchronous to i_clk_sys; configuration is held steady by software.
`timescale 1ns/10ps
`default_nettype none

module mci_delivery
	import mci_pkg::*;
#(
	parameter int TW = TMR_W
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Global control
	input wire logic i_controller_route_enable,
	input wire logic i_pass_through,
	input wire logic i_tie_sel,
	input wire logic [VEC_W-1:0] i_spurious_vec,
	// Per-source vector-priority and destination settings
	input wire logic [NUM_SRC*PRIO_W-1:0] i_src_prio,
	input wire logic [NUM_SRC*VEC_W-1:0] i_src_vec,
	input wire logic [NUM_SRC-1:0] i_src_mask,
	input wire logic [NUM_SRC*NUM_CPU-1:0] i_src_dest,
	// External sources
	input wire logic [NUM_EXT-1:0] i_ext_req,
	input wire logic [NUM_EXT-1:0] i_ext_sense,
	input wire logic [NUM_EXT-1:0] i_ext_pol,
	// Error sources, active low
	input wire logic i_host_bridge_err_n,
	input wire logic i_memory_controller_err_n,
	// Processor side
	input wire logic [PRIO_W-1:0] i_task_prio0,
	input wire logic [PRIO_W-1:0] i_task_prio1,
	input wire logic [NUM_CPU-1:0] i_ack,
	input wire logic [NUM_CPU-1:0] i_end_of_service_command,
	input wire logic [NUM_XCPU-1:0] i_cross_cpu_interrupt,
	// Timers
	input wire logic i_pci_clk,
	input wire logic [NUM_TMR*TW-1:0] i_tmr_base,
	input wire logic [NUM_TMR-1:0] i_tmr_load,
	// Outputs
	output logic [NUM_CPU-1:0] o_irq,
	output logic [VEC_W-1:0] o_ack_vec0,
	output logic [VEC_W-1:0] o_ack_vec1,
	output logic [NUM_CPU-1:0] o_ack_spur,
	output logic o_err_n,
	output logic [NUM_TMR*TW-1:0] o_tmr_count
);

	// Highest-priority requester; lowest index wins ties
	function automatic logic [ID_W-1:0] pick_src(input logic [NUM_SRC-1:0] req,
			input logic [NUM_SRC*PRIO_W-1:0] prio);
		logic [PRIO_W-1:0] best;
		logic [ID_W-1:0] id;
		best = '0;
		id = ID_RST;
		for (int s = NUM_SRC - 1; s >= 0; s--) begin
			if (req[s] && prio[s*PRIO_W +: PRIO_W] >= best) begin
				best = prio[s*PRIO_W +: PRIO_W];
				id = ID_W'(s);
			end
		end
		return id;
	endfunction

	// Highest in-service priority level, zero when idle
	function automatic logic [PRIO_W-1:0] top_level(input logic [15:0] lv);
		logic [PRIO_W-1:0] t;
		t = '0;
		for (int p = 1; p < 16; p++) begin
			if (lv[p]) begin
				t = PRIO_W'(p);
			end
		end
		return t;
	endfunction

	logic [NUM_EXT-1:0] ext_act;
	logic [NUM_EXT-1:0] ext_prev_reg;
	logic err_act;
	logic [NUM_SRC-1:0] pend_dist_reg;
	logic [NUM_SRC-1:0] pend_dir_reg [NUM_CPU];
	logic [NUM_SRC-1:0] req [NUM_CPU];
	logic [NUM_SRC-1:0] ack_hit [NUM_CPU];
	logic [PRIO_W-1:0] task_prio [NUM_CPU];
	logic dist_win;
	logic pt_active;
	logic [ID_W-1:0] sel_id [NUM_CPU];
	logic [ID_W-1:0] irr_id_reg [NUM_CPU];
	logic [NUM_CPU-1:0] irr_ok_reg;
	logic [PRIO_W-1:0] irr_prio [NUM_CPU];
	logic [PRIO_W-1:0] isr_max [NUM_CPU];
	logic [NUM_CPU-1:0] ack_ok;
	logic [NUM_CPU-1:0] deliver;
	logic [15:0] isr_lv_reg [NUM_CPU];
	logic [NUM_SRC-1:0] isr_src_reg [NUM_CPU];
	logic [ID_W-1:0] isr_id_reg [NUM_CPU][16];
	logic pci_prev_reg;
	logic [2:0] pre_cnt_reg;
	logic tick_reg;
	logic [TW-1:0] tmr_cnt_reg [NUM_TMR];
	logic [NUM_TMR-1:0] tmr_evt_reg;
	logic [NUM_CPU-1:0] irq_reg;
	logic [VEC_W-1:0] ack_vec_reg [NUM_CPU];
	logic [NUM_CPU-1:0] spur_reg;
	logic err_n_reg;

	// Source qualification and per-processor request vectors
	always_comb begin
		ext_act = ~(i_ext_req ^ i_ext_pol); // Polarity 1 means active high
		err_act = ~(i_host_bridge_err_n & i_memory_controller_err_n);
		task_prio[0] = i_task_prio0;
		task_prio[1] = i_task_prio1;
		pt_active = i_controller_route_enable & i_pass_through;
		// Lower task wins, tie bit breaks equality: set gives processor 1, clear gives processor 0
		dist_win = (task_prio[0] == task_prio[1]) ? i_tie_sel
			: (task_prio[1] < task_prio[0]);
		for (int c = 0; c < NUM_CPU; c++) begin
			for (int s = 0; s < NUM_SRC; s++) begin
				if ((s < TMR_IDX) || (s == ERR_IDX)) begin
					req[c][s] = pend_dist_reg[s] & i_src_dest[s*NUM_CPU+c]
						& ~isr_src_reg[1-c][s]
						& ~(i_src_dest[s*NUM_CPU] & i_src_dest[s*NUM_CPU+1]
						& (dist_win != c[0]));
				end else begin
					req[c][s] = pend_dir_reg[c][s];
				end
				// Masked conditions stay pending but do not request
				req[c][s] = req[c][s] & ~i_src_mask[s]
					& ~(pt_active && s == 0)
					& (i_src_prio[s*PRIO_W +: PRIO_W] != '0);
			end
			sel_id[c] = pick_src(req[c], i_src_prio);
			irr_prio[c] = i_src_prio[irr_id_reg[c]*PRIO_W +: PRIO_W];
			isr_max[c] = top_level(isr_lv_reg[c]);
			// Request may vanish after the pin rose; then the answer is spurious
			ack_ok[c] = irr_ok_reg[c] & req[c][irr_id_reg[c]];
			deliver[c] = ack_ok[c] & (irr_prio[c] > task_prio[c])
				& (irr_prio[c] > isr_max[c]);
			ack_hit[c] = (i_ack[c] && ack_ok[c]) ? (NUM_SRC'(1) << irr_id_reg[c]) : '0;
		end
	end

	// Distributed pending bits: level follows input, edge set wins over clear
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			ext_prev_reg <= ext_act; // Current level, so release shows no false edge
			pend_dist_reg <= '0;
		end else begin
			ext_prev_reg <= ext_act;
			for (int s = 0; s < NUM_EXT; s++) begin
				if (i_ext_sense[s]) begin
					pend_dist_reg[s] <= ext_act[s];
				end else if (ext_act[s] & ~ext_prev_reg[s]) begin
					pend_dist_reg[s] <= 1'b1;
				end else if (ack_hit[0][s] | ack_hit[1][s]) begin
					pend_dist_reg[s] <= 1'b0;
				end
			end
			pend_dist_reg[ERR_IDX] <= err_act;
		end
	end

	// Direct pending bits, one per processor; repeats merge into one bit
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			pend_dir_reg[0] <= '0;
			pend_dir_reg[1] <= '0;
		end else begin
			for (int c = 0; c < NUM_CPU; c++) begin
				for (int k = 0; k < NUM_XCPU; k++) begin
					if (i_cross_cpu_interrupt[k] && i_src_dest[(XCPU_IDX+k)*NUM_CPU+c]) begin
						pend_dir_reg[c][XCPU_IDX+k] <= 1'b1;
					end else if (ack_hit[c][XCPU_IDX+k]) begin
						pend_dir_reg[c][XCPU_IDX+k] <= 1'b0;
					end
				end
				for (int k = 0; k < NUM_TMR; k++) begin
					if (tmr_evt_reg[k] && i_src_dest[(TMR_IDX+k)*NUM_CPU+c]) begin
						pend_dir_reg[c][TMR_IDX+k] <= 1'b1;
					end else if (ack_hit[c][TMR_IDX+k]) begin
						pend_dir_reg[c][TMR_IDX+k] <= 1'b0;
					end
				end
			end
		end
	end

	// Request register: frozen on acknowledge so the vector cannot change
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			irr_ok_reg <= '0;
			irr_id_reg[0] <= ID_RST;
			irr_id_reg[1] <= ID_RST;
		end else begin
			for (int c = 0; c < NUM_CPU; c++) begin
				if (!i_ack[c]) begin
					irr_id_reg[c] <= sel_id[c];
					irr_ok_reg[c] <= |req[c];
				end
			end
		end
	end

	// In-service tracking; clear first so a same-cycle acknowledge still sets
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			for (int c = 0; c < NUM_CPU; c++) begin
				isr_lv_reg[c] <= '0;
				isr_src_reg[c] <= '0;
			end
		end else begin
			for (int c = 0; c < NUM_CPU; c++) begin
				if (i_end_of_service_command[c] && isr_max[c] != '0) begin
					isr_lv_reg[c][isr_max[c]] <= 1'b0;
					isr_src_reg[c][isr_id_reg[c][isr_max[c]]] <= 1'b0;
				end
				if (i_ack[c] && ack_ok[c]) begin
					isr_lv_reg[c][irr_prio[c]] <= 1'b1;
					isr_src_reg[c][irr_id_reg[c]] <= 1'b1;
					isr_id_reg[c][irr_prio[c]] <= irr_id_reg[c];
				end
			end
		end
	end

	// Acknowledge answer; legacy second fetch never reaches this block
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			ack_vec_reg[0] <= VEC_RST;
			ack_vec_reg[1] <= VEC_RST;
			spur_reg <= '0;
		end else begin
			for (int c = 0; c < NUM_CPU; c++) begin
				if (i_ack[c]) begin
					spur_reg[c] <= ~ack_ok[c];
					ack_vec_reg[c] <= ack_ok[c] ? i_src_vec[irr_id_reg[c]*VEC_W +: VEC_W]
						: i_spurious_vec;
				end
			end
		end
	end

	// Request pins and external error signal
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			irq_reg <= '0;
			err_n_reg <= 1'b1;
		end else begin
			if (!i_controller_route_enable) begin
				irq_reg <= {1'b0, err_act};
			end else begin
				irq_reg <= {deliver[1], deliver[0] | (pt_active & ext_act[0])};
			end
			err_n_reg <= ~err_act;
		end
	end

	// Prescaler: one tick every eighth rising PCI clock edge
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			pci_prev_reg <= i_pci_clk; // No false rise right after reset
			pre_cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			pci_prev_reg <= i_pci_clk;
			tick_reg <= 1'b0;
			if (i_pci_clk & ~pci_prev_reg) begin
				pre_cnt_reg <= pre_cnt_reg + 3'h1;
				tick_reg <= (pre_cnt_reg == PRESCALE_LAST);
			end
		end
	end

	// Timers: base count zero keeps a timer silent after reset
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			tmr_evt_reg <= '0;
			for (int k = 0; k < NUM_TMR; k++) begin
				tmr_cnt_reg[k] <= '0;
			end
		end else begin
			for (int k = 0; k < NUM_TMR; k++) begin
				tmr_evt_reg[k] <= 1'b0;
				if (i_tmr_load[k]) begin
					tmr_cnt_reg[k] <= i_tmr_base[k*TW +: TW];
				end else if (tick_reg) begin
					if (tmr_cnt_reg[k] == '0) begin
						tmr_cnt_reg[k] <= i_tmr_base[k*TW +: TW];
					end else begin
						tmr_cnt_reg[k] <= tmr_cnt_reg[k] - TW'(1);
						tmr_evt_reg[k] <= (tmr_cnt_reg[k] == TW'(1));
					end
				end
			end
		end
	end

	// Output wiring, all from flip-flops
	assign o_irq = irq_reg;
	assign o_ack_vec0 = ack_vec_reg[0];
	assign o_ack_vec1 = ack_vec_reg[1];
	assign o_ack_spur = spur_reg;
	assign o_err_n = err_n_reg;
	assign o_tmr_count = {tmr_cnt_reg[3], tmr_cnt_reg[2], tmr_cnt_reg[1], tmr_cnt_reg[0]};

	// Checks
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);
	sequence s_ack_taken0;
		i_ack[0] && ack_ok[0];
	endsequence
	a_prio_zero: assert property (deliver[0] |-> irr_prio[0] != '0)
		else $error("zero priority delivered");
	a_task_gate: assert property (i_controller_route_enable && !i_pass_through
		&& i_task_prio0 == PRIO_MAX |=> !o_irq[0])
		else $error("task priority not honoured");
	a_nest_gate: assert property (deliver[0] |-> irr_prio[0] > isr_max[0])
		else $error("in-service interrupt preempted");
	a_isr_set: assert property (s_ack_taken0 |=> isr_src_reg[0][$past(irr_id_reg[0])])
		else $error("acknowledged source not in service");
	a_spur_vec: assert property (i_ack[0] && !ack_ok[0] |=>
		o_ack_vec0 == $past(i_spurious_vec) && o_ack_spur[0])
		else $error("spurious vector not returned");
	a_xcpu_set: assert property (i_cross_cpu_interrupt[0]
		&& i_src_dest[XCPU_IDX*NUM_CPU] |=> pend_dir_reg[0][XCPU_IDX])
		else $error("cross cpu dispatch lost");
	a_pass_route: assert property (i_controller_route_enable && i_pass_through
		&& ext_act[0] |=> o_irq[0])
		else $error("pass-through not routed");
	a_err_direct: assert property (!i_controller_route_enable |=>
		o_irq[0] == $past(err_act) && !o_irq[1])
		else $error("error not routed to processor 0");
	a_err_out: assert property (err_act |=> !o_err_n)
		else $error("error output missing");
	a_tick_gap: assert property (tick_reg |=> !tick_reg [*7])
		else $error("prescaler faster than one in eight");
endmodule // mci_delivery

`default_nettype wire

// ### mci_delivery_bench.sv
// Self-checking bench for the two-processor interrupt delivery block.
// Assumes the delivery module and the core model are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module mci_delivery_bench;
	import mci_pkg::*;
	localparam logic [VEC_W-1:0] SV = 8'h3c;
	logic i_clk_sys, i_rst_n, en, pass, tie, hb_n, mc_n, pclk, s, err_n;
	logic [NUM_SRC*PRIO_W-1:0] prio;
	logic [NUM_SRC*VEC_W-1:0] vec;
	logic [NUM_SRC-1:0] mask;
	logic [NUM_SRC*NUM_CPU-1:0] dest;
	logic [NUM_EXT-1:0] req, sense, pol;
	logic [PRIO_W-1:0] tp0, tp1;
	logic [NUM_CPU-1:0] ack, eos, irq, spur;
	logic [NUM_XCPU-1:0] xc;
	logic [NUM_TMR*16-1:0] base, cnt;
	logic [NUM_TMR-1:0] load;
	logic [VEC_W-1:0] av0, av1, v;
	int n_errors, checked, npr;

	mci_delivery #(.TW(16)) dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
		.i_controller_route_enable(en), .i_pass_through(pass), .i_tie_sel(tie),
		.i_spurious_vec(SV), .i_src_prio(prio), .i_src_vec(vec), .i_src_mask(mask),
		.i_src_dest(dest), .i_ext_req(req), .i_ext_sense(sense), .i_ext_pol(pol),
		.i_host_bridge_err_n(hb_n), .i_memory_controller_err_n(mc_n),
		.i_task_prio0(tp0), .i_task_prio1(tp1), .i_ack(ack),
		.i_end_of_service_command(eos), .i_cross_cpu_interrupt(xc), .i_pci_clk(pclk),
		.i_tmr_base(base), .i_tmr_load(load), .o_irq(irq), .o_ack_vec0(av0),
		.o_ack_vec1(av1), .o_ack_spur(spur), .o_err_n(err_n), .o_tmr_count(cnt));
	mci_cpu_model cpu0 (.i_clk_sys(i_clk_sys), .i_vec(av0), .i_spur(spur[0]),
		.o_ack(ack[0]), .o_eos(eos[0]));
	mci_cpu_model cpu1 (.i_clk_sys(i_clk_sys), .i_vec(av1), .i_spur(spur[1]),
		.o_ack(ack[1]), .o_eos(eos[1]));

	// System clock, 100 ns period
	initial begin
		i_clk_sys = 1'b0;
		forever #50 i_clk_sys = ~i_clk_sys;
	end

	// PCI clock at half the system rate; rises counted for the prescaler check
	always @(negedge i_clk_sys) begin
		pclk <= ~pclk;
		if (!pclk) npr <= npr + 1;
	end

	task automatic complete_run();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic timeout();
		n_errors++;
		$display("ERROR t=%0t wait expired %h %h", $time, irq, cnt[15:0]);
		complete_run();
	endtask

	task automatic settle();
		repeat (6) @(negedge i_clk_sys);
	endtask

	task automatic src(input int k, input logic [3:0] p, input logic [1:0] d);
		prio[4*k+:4] = p;
		dest[2*k+:2] = d;
	endtask

	task automatic pulse(input int k);
		@(negedge i_clk_sys) req[k] = 1'b1;
		@(negedge i_clk_sys) req[k] = 1'b0;
	endtask

	// Bounded wait for a request pin
	task automatic wait_irq(input int c);
		repeat (40) if (irq[c] !== 1'b1) @(negedge i_clk_sys);
		if (irq[c] !== 1'b1) timeout();
		checked++;
	endtask

	// Bounded wait for timer 0 to show a count
	task automatic wait_cnt(input logic [15:0] e);
		repeat (200) if (cnt[15:0] !== e) @(negedge i_clk_sys);
		if (cnt[15:0] !== e) timeout();
	endtask

	task automatic rd(input int c, input logic [7:0] e, input logic es);
		if (c == 0) cpu0.ack_read(v, s);
		else cpu1.ack_read(v, s);
		`CHK(v, e)
		`CHK(s, es)
	endtask

	task automatic es(input int c);
		if (c == 0) cpu0.end_service();
		else cpu1.end_service();
	endtask

	task automatic t_disabled();
		hb_n = 1'b0;
		settle();
		`CHK(irq, 2'b01)
		hb_n = 1'b1;
		mc_n = 1'b0;
		en = 1'b1;
		settle();
		`CHK(irq, 2'b00)
		`CHK(err_n, 1'b0)
		mc_n = 1'b1;
		settle();
		`CHK(err_n, 1'b1)
	endtask

	// Legacy line bypasses priority zero only while pass-through is on
	task automatic t_pass();
		req[0] = 1'b1;
		settle();
		`CHK(irq, 2'b01)
		req[0] = 1'b0;
		pass = 1'b0;
		src(0, 4'h9, 2'b10);
		settle();
		req[0] = 1'b1;
		wait_irq(1);
		`CHK(irq[0], 1'b0)
		rd(1, 8'h40, 1'b0);
		req[0] = 1'b0;
		es(1);
	endtask

	task automatic t_order();
		src(1, 4'h5, 2'b01);
		src(2, 4'h5, 2'b01);
		src(15, 4'h0, 2'b01);
		tp0 = 4'h2;
		req = 16'h8006;
		@(negedge i_clk_sys) req = 16'h0000;
		wait_irq(0);
		rd(0, 8'h41, 1'b0);
		settle();
		`CHK(irq[0], 1'b0)
		es(0);
		wait_irq(0);
		rd(0, 8'h42, 1'b0);
		es(0);
		settle();
		`CHK(irq, 2'b00)
		rd(0, SV, 1'b1);
		tp0 = 4'h0;
	endtask

	task automatic t_task();
		src(3, 4'hf, 2'b01);
		tp0 = 4'hf;
		mask[3] = 1'b1;
		pulse(3);
		settle();
		mask[3] = 1'b0;
		settle();
		`CHK(irq[0], 1'b0)
		tp0 = 4'he;
		wait_irq(0);
		rd(0, 8'h43, 1'b0);
		es(0);
		tp0 = 4'h0;
	endtask

	task automatic t_spur();
		src(5, 4'h6, 2'b01);
		src(4, 4'h6, 2'b01);
		req[5] = 1'b1;
		wait_irq(0);
		req[5] = 1'b0;
		settle();
		rd(0, SV, 1'b1);
		pulse(4);
		wait_irq(0);
		mask[4] = 1'b1;
		settle();
		rd(0, SV, 1'b1);
		mask[4] = 1'b0;
		wait_irq(0);
		rd(0, 8'h44, 1'b0);
		es(0);
	endtask

	task automatic t_xcpu();
		for (int k = 0; k < 4; k++) begin
			src(20 + k, 4'h7, 2'b11);
			repeat (2) begin
				@(negedge i_clk_sys) xc[k] = 1'b1;
				@(negedge i_clk_sys) xc[k] = 1'b0;
			end
			wait_irq(0);
			wait_irq(1);
			rd(0, 8'h54 + 8'(k), 1'b0);
			rd(1, 8'h54 + 8'(k), 1'b0);
			es(0);
			es(1);
			settle();
			rd(0, SV, 1'b1);
			rd(1, SV, 1'b1);
		end
	endtask

	// Lower task wins; equal tasks fall to the tie select
	task automatic t_dist();
		logic [3:0] ta [4] = '{4'h1, 4'h3, 4'h2, 4'h2};
		logic [3:0] tb [4] = '{4'h3, 4'h1, 4'h2, 4'h2};
		logic tt [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
		logic w [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
		src(6, 4'h8, 2'b11);
		for (int k = 0; k < 4; k++) begin
			tp0 = ta[k];
			tp1 = tb[k];
			tie = tt[k];
			pulse(6);
			wait_irq(int'(w[k]));
			settle();
			`CHK(irq[!w[k]], 1'b0)
			rd(int'(w[k]), 8'h46, 1'b0);
			es(int'(w[k]));
		end
	endtask

	task automatic t_timer();
		int r0;
		base[15:0] = 16'h0005;
		load[0] = 1'b1;
		@(negedge i_clk_sys) load[0] = 1'b0;
		wait_cnt(16'h0004);
		r0 = npr;
		wait_cnt(16'h0003);
		`CHK(npr - r0, 8)
	endtask

	// Inputs settled at time zero; pass-through on as after power-on
	initial begin
		{i_rst_n, en, tie, pclk, npr, n_errors, checked} = '0;
		{pass, hb_n, mc_n} = 3'h7;
		{prio, dest, req, xc, base, load, tp0, tp1} = '0;
		mask = 25'h10f0000;
		sense = 16'h0021;
		pol = 16'hffff;
		for (int k = 0; k < NUM_SRC; k++) vec[8*k+:8] = 8'h40 + 8'(k);
		repeat (8) @(negedge i_clk_sys);
		`CHK({irq, err_n, spur}, 5'h04)
		i_rst_n = 1'b1;
		@(negedge i_clk_sys);
		t_disabled();
		t_pass();
		t_order();
		t_task();
		t_spur();
		t_xcpu();
		t_dist();
		t_timer();
		complete_run();
	end
endmodule // mci_delivery_bench
`default_nettype wire

// ### mci_pkg.sv
// Shared constants for the two-processor interrupt delivery block.
// Assumes source numbering: externals first, then timers, cross-cpu channels, error.
package mci_pkg;
	localparam int NUM_CPU = 2;
	localparam int NUM_EXT = 16;
	localparam int NUM_TMR = 4;
	localparam int NUM_XCPU = 4;
	localparam int NUM_SRC = 25;
	localparam int TMR_IDX = 16;
	localparam int XCPU_IDX = 20;
	localparam int ERR_IDX = 24;
	localparam int PRIO_W = 4;
	localparam int VEC_W = 8;
	localparam int ID_W = 5;
	localparam int TMR_W = 16;
	localparam logic [PRIO_W-1:0] PRIO_MAX = 4'hf;
	localparam logic [2:0] PRESCALE_LAST = 3'h7; // Divide by eight
	localparam logic [VEC_W-1:0] VEC_RST = 8'h00;
	localparam logic [ID_W-1:0] ID_RST = 5'h00;
endpackage
